//--- hdl/msdt_timer.sv
// Millisecond decimal stopwatch timer with prescaler, registers and interrupt
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps

module msdt_timer (
	input  wire logic        CORE_CLK,
	input  wire logic        RESET,
	input  wire logic        TICK_2048HZ,
	input  wire logic [15:0] REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic        REG_WIDE,
	output logic      [15:0] REG_RDATA,
	output logic             MS_TIMER_IRQ,
	output logic             IRQ
);

	// Registered state and its next value
	msdt_pkg::msdt_state_t state_reg;
	msdt_pkg::msdt_state_t state_next;

	// Decimal counter chain
	logic [3:0]  digit_val   [msdt_pkg::MSDT_DIGITS];
	logic        digit_inc   [msdt_pkg::MSDT_DIGITS];
	logic        digit_clr   [msdt_pkg::MSDT_DIGITS];
	logic        digit_carry [msdt_pkg::MSDT_DIGITS];
	logic [11:0] ms_count_bits;

	// Register decode
	logic        hit_low;
	logic        hit_high;
	logic        hit_control;
	logic        hit_status;
	logic        hit_mask;
	logic        wr_low;
	logic        wr_high;
	logic        wr_count;

	// Prescaler and events
	logic [11:0] presc_sum;
	logic        presc_wrap;
	logic        count_enable;
	logic        evt_tenth;
	logic        evt_second;
	logic        period_event;
	logic [1:0]  evt_set;
	logic [1:0]  evt_clear;
	logic [1:0]  status_upd;

	// Read data views
	logic [7:0]  ms_count_low;
	logic [7:0]  ms_count_high;
	logic [7:0]  ms_timer_control;
	logic [15:0] read_value;

	// Address decode for the five registers
	assign hit_low     = (REG_ADDR == msdt_pkg::MSDT_ADDR_COUNT_LOW);
	assign hit_high    = (REG_ADDR == msdt_pkg::MSDT_ADDR_COUNT_HIGH);
	assign hit_control = (REG_ADDR == msdt_pkg::MSDT_ADDR_CONTROL);
	assign hit_status  = (REG_ADDR == msdt_pkg::MSDT_ADDR_IRQ_STATUS);
	assign hit_mask    = (REG_ADDR == msdt_pkg::MSDT_ADDR_IRQ_MASK);

	// Count writes; a word write at the low address covers both bytes
	assign wr_low   = REG_WR & hit_low;
	assign wr_high  = REG_WR & (hit_high | (hit_low & REG_WIDE));
	assign wr_count = wr_low | wr_high;

	// Fractional prescaler: add the enable rate, wrap at the tick rate
	assign presc_sum  = {1'b0, state_reg.presc} + msdt_pkg::MSDT_PRESC_STEP;
	assign presc_wrap = TICK_2048HZ & (presc_sum >= msdt_pkg::MSDT_PRESC_MOD);

	// Enable only while running, and not in a cycle that clears the count
	assign count_enable = presc_wrap & state_reg.run & ~wr_count;

	// Digit controls: units take the enable, higher digits the carry below
	assign digit_inc[msdt_pkg::MSDT_UNITS]    = count_enable;
	assign digit_inc[msdt_pkg::MSDT_TENS]     =
		digit_carry[msdt_pkg::MSDT_UNITS];
	assign digit_inc[msdt_pkg::MSDT_HUNDREDS] =
		digit_carry[msdt_pkg::MSDT_TENS];
	assign digit_clr[msdt_pkg::MSDT_UNITS]    = wr_low;
	assign digit_clr[msdt_pkg::MSDT_TENS]     = wr_high;
	assign digit_clr[msdt_pkg::MSDT_HUNDREDS] = wr_high;

	// Three decimal stages, 000 to 999
	genvar gi;
	generate
		for (gi = 0; gi < msdt_pkg::MSDT_DIGITS; gi = gi + 1) begin : g_digit
			msdt_bcd_digit u_digit (
				.clk    (CORE_CLK),
				.rst    (RESET),
				.inc_en (digit_inc[gi]),
				.clr    (digit_clr[gi]),
				.digit  (digit_val[gi]),
				.carry  (digit_carry[gi])
			);
		end
	endgenerate

	// Packed count, hundreds in the top digit
	assign ms_count_bits = {digit_val[msdt_pkg::MSDT_HUNDREDS],
	                        digit_val[msdt_pkg::MSDT_TENS],
	                        digit_val[msdt_pkg::MSDT_UNITS]};

	// Events from the carry chain; cleared digits produce no event
	assign evt_tenth  = digit_carry[msdt_pkg::MSDT_TENS] & ~wr_high;
	assign evt_second = digit_carry[msdt_pkg::MSDT_HUNDREDS] & ~wr_high;

	// Rate select: 10 Hz on each hundreds step, 1 Hz on 999 to 000
	assign period_event = state_reg.sel ? evt_second : evt_tenth;

	// Sticky status: set from events, cleared by writing ones
	assign evt_set = {evt_second, evt_tenth};
	assign evt_clear = (REG_WR & hit_status) ? REG_WDATA[1:0] : 2'h0;
	assign status_upd = (state_reg.status & ~evt_clear) | evt_set;

	// Byte views of the registers
	assign ms_count_high = ms_count_bits[11:4];
	assign ms_count_low  = {ms_count_bits[3:0], 4'h0};
	assign ms_timer_control = {6'h00, state_reg.sel, state_reg.run};

	// Read multiplexer; the word view pairs high byte over low byte
	always_comb begin
		read_value = msdt_pkg::MSDT_RST_RDATA;
		if (hit_low) begin
			if (REG_WIDE) begin
				read_value = {ms_count_high, ms_count_low};
			end else begin
				read_value = {8'h00, ms_count_low};
			end
		end else if (hit_high) begin
			read_value = {8'h00, ms_count_high};
		end else if (hit_control) begin
			read_value = {8'h00, ms_timer_control};
		end else if (hit_status) begin
			read_value = {14'h0, state_reg.status};
		end else if (hit_mask) begin
			read_value = {14'h0, state_reg.mask};
		end
	end

	// Next-state logic for control, prescaler, interrupts and read data
	always_comb begin
		state_next = state_reg;

		// Control register write
		if (REG_WR && hit_control) begin
			state_next.run = REG_WDATA[msdt_pkg::MSDT_RUN_BIT];
			state_next.sel = REG_WDATA[msdt_pkg::MSDT_SEL_BIT];
		end

		// Mask register write
		if (REG_WR && hit_mask) begin
			state_next.mask = REG_WDATA[1:0];
		end

		// Prescaler: cleared by any count write, else steps on each tick while running
		if (wr_count) begin
			state_next.presc = msdt_pkg::MSDT_PRESC_RST;
		end else if (TICK_2048HZ && state_reg.run) begin
			if (presc_wrap) begin
				state_next.presc =
					presc_sum[10:0] - msdt_pkg::MSDT_PRESC_MOD[10:0];
			end else begin
				state_next.presc = presc_sum[10:0];
			end
		end

		// Status with set winning over a same-cycle clear
		state_next.status = status_upd;

		// One-cycle timer request at the selected rate
		state_next.irq_pulse = period_event;

		// Level interrupt from unmasked sticky bits
		state_next.irq_level = |(status_upd & state_reg.mask);

		// Read data stand the cycle after the strobe only
		if (REG_RD) begin
			state_next.rdata = read_value;
		end else begin
			state_next.rdata = msdt_pkg::MSDT_RST_RDATA;
		end
	end

	// State register
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	assign REG_RDATA    = state_reg.rdata;
	assign MS_TIMER_IRQ = state_reg.irq_pulse;
	assign IRQ          = state_reg.irq_level;

endmodule : msdt_timer

//--- hdl/msdt_pkg.sv
// Package with register map, field layout and timing constants of the ms timer
package msdt_pkg;

	// Register offsets on the byte-addressed special function space
	localparam logic [15:0] MSDT_ADDR_COUNT_LOW  = 16'hf080;
	localparam logic [15:0] MSDT_ADDR_COUNT_HIGH = 16'hf081;
	localparam logic [15:0] MSDT_ADDR_CONTROL    = 16'hf082;
	localparam logic [15:0] MSDT_ADDR_IRQ_STATUS = 16'hf083;
	localparam logic [15:0] MSDT_ADDR_IRQ_MASK   = 16'hf084;

	// Control register fields
	localparam int MSDT_RUN_BIT = 0;
	localparam int MSDT_SEL_BIT = 1;

	// Interrupt status and mask fields
	localparam int MSDT_EVT_TENTH  = 0;
	localparam int MSDT_EVT_SECOND = 1;
	localparam int MSDT_EVT_COUNT  = 2;

	// Reset values
	localparam logic [7:0]  MSDT_RST_BYTE  = 8'h00;
	localparam logic [15:0] MSDT_RST_RDATA = 16'h0000;
	localparam logic [1:0]  MSDT_RST_EVT   = 2'h0;

	// Count layout: three decimal digits, four bits each
	localparam int          MSDT_DIGITS    = 3;
	localparam int          MSDT_DIGIT_W   = 4;
	localparam logic [3:0]  MSDT_DIGIT_MAX = 4'h9;
	localparam logic [3:0]  MSDT_DIGIT_ZERO = 4'h0;
	localparam int          MSDT_UNITS     = 0;
	localparam int          MSDT_TENS      = 1;
	localparam int          MSDT_HUNDREDS  = 2;

	// Prescaler: tick rate in, enable rate out, fractional divide by 2 or 3
	localparam int          MSDT_TICK_HZ   = 2048;
	localparam int          MSDT_ENABLE_HZ = 1000;
	localparam int          MSDT_PRESC_W   = 11;
	localparam logic [11:0] MSDT_PRESC_MOD = 12'(MSDT_TICK_HZ);
	localparam logic [11:0] MSDT_PRESC_STEP = 12'(MSDT_ENABLE_HZ);
	localparam logic [10:0] MSDT_PRESC_RST = 11'h000;

	// Registered state of the top module, apart from the count digits held in the digit stages
	typedef struct packed {
		logic [10:0] presc;
		logic        run;
		logic        sel;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic [15:0] rdata;
		logic        irq_pulse;
		logic        irq_level;
	} msdt_state_t;

	// State of one decimal digit
	typedef struct packed {
		logic [3:0] value;
	} msdt_digit_t;

endpackage : msdt_pkg

//--- hdl/msdt_bcd_digit.sv
// One decimal counter stage with clear and ripple carry
`timescale 1ns/100ps

module msdt_bcd_digit (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       inc_en,
	input  wire logic       clr,
	output logic [3:0]      digit,
	output logic            carry
);

	msdt_pkg::msdt_digit_t state_reg;
	msdt_pkg::msdt_digit_t state_next;

	// Carry out when stepping past nine, the source of wrap events
	assign carry = inc_en & (state_reg.value == msdt_pkg::MSDT_DIGIT_MAX);
	assign digit = state_reg.value;

	// Clear beats increment; nine rolls to zero
	always_comb begin
		state_next = state_reg;
		if (clr) begin
			state_next.value = msdt_pkg::MSDT_DIGIT_ZERO;
		end else if (carry) begin
			state_next.value = msdt_pkg::MSDT_DIGIT_ZERO;
		end else if (inc_en) begin
			state_next.value = state_reg.value + 4'h1;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : msdt_bcd_digit

//--- testbench/msdt_timer_chk_asserts.sv
// Checker of bus answers, count clears and interrupt timing of the timer
`timescale 1ns/100ps
module msdt_timer_chk (
	input wire logic        CORE_CLK,
	input wire logic        RESET,
	input wire logic        TICK_2048HZ,
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic        REG_WIDE,
	input wire logic [15:0] REG_RDATA,
	input wire logic        MS_TIMER_IRQ,
	input wire logic        IRQ
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	localparam logic [15:0] lo_adr = msdt_pkg::MSDT_ADDR_COUNT_LOW;
	localparam logic [15:0] hi_adr = msdt_pkg::MSDT_ADDR_COUNT_HIGH;
	localparam logic [15:0] ct_adr = msdt_pkg::MSDT_ADDR_CONTROL;
	// Decoded bus cycles
	wire logic rd_lo = REG_RD && !REG_WIDE && REG_ADDR == lo_adr;
	wire logic rd_hi = REG_RD && REG_ADDR == hi_adr;
	wire logic wr_lo = REG_WR && REG_ADDR == lo_adr;
	wire logic wr_hi = REG_WR && REG_ADDR == hi_adr;
	wire logic rd_ct = REG_RD && REG_ADDR == ct_adr;
	wire logic wr_ct = REG_WR && REG_ADDR == ct_adr;
	wire logic rd_un = REG_RD && !(REG_ADDR inside {[16'hf080:16'hf084]});
	wire logic [1:0] wd_lo = REG_WDATA[1:0];
	a_rdata_idle: assert property (
		!$past(REG_RD) |-> REG_RDATA == 16'h0000)
		else $error("read data outside read cycle");
	a_unmapped_zero: assert property (
		rd_un |=> REG_RDATA == 16'h0000)
		else $error("unmapped read not zero");
	a_low_layout: assert property (
		rd_lo |=> REG_RDATA[15:8] == 8'h00 && REG_RDATA[3:0] == 4'h0)
		else $error("low count byte layout wrong");
	a_pulse_single: assert property (
		MS_TIMER_IRQ |=> !MS_TIMER_IRQ)
		else $error("timer request longer than a cycle");
	a_pulse_cause: assert property (
		MS_TIMER_IRQ |-> $past(TICK_2048HZ) || $past(TICK_2048HZ, 2))
		else $error("timer request without a tick");
	a_low_clear: assert property (
		wr_lo ##2 rd_lo |=> REG_RDATA == 16'h0000)
		else $error("low count not cleared");
	a_high_clear: assert property (
		wr_hi ##2 rd_hi |=> REG_RDATA == 16'h0000)
		else $error("high count not cleared");
	a_irq_cause: assert property (
		$rose(IRQ) |-> $past(TICK_2048HZ) || $past(TICK_2048HZ, 2)
			|| $past(REG_WR) || $past(REG_WR, 2))
		else $error("interrupt rose without cause");
	a_ctrl_back: assert property (
		wr_ct ##2 rd_ct |=> REG_RDATA[1:0] == $past(wd_lo, 3))
		else $error("control readback wrong");
	c_pulse: cover property (MS_TIMER_IRQ);
	c_irq: cover property ($rose(IRQ));
	c_word: cover property (REG_RD && REG_WIDE);
endmodule : msdt_timer_chk

//--- testbench/millisecond_decimal_timer_bench.sv
// Randomised self-checking bench of the millisecond decimal timer
`timescale 1ns/100ps
module millisecond_decimal_timer_bench;
	localparam logic [15:0] lo = msdt_pkg::MSDT_ADDR_COUNT_LOW;
	localparam logic [15:0] hi = msdt_pkg::MSDT_ADDR_COUNT_HIGH;
	localparam logic [15:0] ct = msdt_pkg::MSDT_ADDR_CONTROL;
	localparam logic [15:0] sa = msdt_pkg::MSDT_ADDR_IRQ_STATUS;
	localparam logic [15:0] ma = msdt_pkg::MSDT_ADDR_IRQ_MASK;
	logic        CORE_CLK = 1'b0;
	logic        RESET = 1'b1;
	logic        TICK_2048HZ = 1'b0;
	logic [15:0] REG_ADDR = 16'h0000;
	logic [15:0] REG_WDATA = 16'h0000;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic        REG_WIDE = 1'b0;
	wire  [15:0] REG_RDATA;
	wire         MS_TIMER_IRQ;
	wire         IRQ;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          acc = 0, cnt = 0, pul = 0, seen = 0, cyc = 0;
	logic [1:0]  st = 2'h0, msk = 2'h0;
	logic        sel = 1'b0, run = 1'b0;
	logic [15:0] twice_val;
	msdt_timer u_msdt_timer (.CORE_CLK(CORE_CLK), .RESET(RESET),
		.TICK_2048HZ(TICK_2048HZ), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WIDE(REG_WIDE),
		.REG_RDATA(REG_RDATA), .MS_TIMER_IRQ(MS_TIMER_IRQ), .IRQ(IRQ));
	initial begin
		forever #4 CORE_CLK = ~CORE_CLK;
	end
	// Pulse counter and hang guard
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (MS_TIMER_IRQ === 1'b1) seen <= seen + 1;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	// Expected register image of a decimal count
	function automatic logic [15:0] bcd(input int c);
		return {4'(c / 100), 4'(c / 10 % 10), 4'(c % 10), 4'h0};
	endfunction : bcd
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WIDE <= 1'b0;
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask : wr
	// Word write at the low address, which clears both count bytes
	task automatic wr_word(input logic [15:0] d);
		@(posedge CORE_CLK);
		REG_ADDR <= lo;
		REG_WDATA <= d;
		REG_WIDE <= 1'b1;
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask : wr_word
	task automatic rdv(input logic [15:0] a, input logic w,
		output logic [15:0] v);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WIDE <= w;
		REG_RD <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1 v = REG_RDATA;
	endtask : rdv
	task automatic rd(input logic [15:0] a, input logic w,
		input logic [15:0] e, input string n);
		logic [15:0] v;
		rdv(a, w, v);
		chk(n, e, v);
	endtask : rd
	// Read the running word twice until both agree, a bounded number of tries
	task automatic rd_twice(output logic [15:0] v);
		logic [15:0] w;
		int k;
		k = 0;
		rdv(lo, 1'b1, v);
		rdv(lo, 1'b1, w);
		while (v !== w && k < 16) begin
			v = w;
			rdv(lo, 1'b1, w);
			k++;
		end
		chk("read twice", v, w);
	endtask : rd_twice
	// Every register and one unmapped address read zero after reset
	task automatic reset_check(input string n);
		for (int i = 0; i < 6; i++) begin
			rd(lo + 16'(i), 1'b0, 16'h0000, n);
		end
		$display("test %s done", n);
	endtask : reset_check
	// Ticks with random gaps, back to back among them, and the count model
	task automatic ticks(input int n);
		int g;
		for (int i = 0; i < n; i++) begin
			@(posedge CORE_CLK);
			TICK_2048HZ <= 1'b1;
			if (run) acc += 1000;
			if (acc >= 2048) begin
				acc -= 2048;
				cnt = (cnt + 1) % 1000;
				if (cnt % 100 == 0) st[0] = 1'b1;
				if (cnt == 0) st[1] = 1'b1;
				if (cnt % 100 == 0 && (!sel || cnt == 0)) pul++;
			end
			g = $urandom_range(0, 2);
			repeat (g) begin
				@(posedge CORE_CLK);
				TICK_2048HZ <= 1'b0;
			end
		end
		@(posedge CORE_CLK);
		TICK_2048HZ <= 1'b0;
	endtask : ticks
	task automatic check_all(input string n);
		logic [15:0] b;
		b = bcd(cnt);
		rd(lo, 1'b0, {8'h00, b[7:0]}, n);
		rd(hi, 1'b0, {8'h00, b[15:8]}, n);
		rd(lo, 1'b1, b, n);
		rd(sa, 1'b0, {14'h0, st}, n);
		chk(n, 16'(pul), 16'(seen));
		chk(n, {15'h0, |(st & msk)}, {15'h0, IRQ});
		$display("test %s done", n);
	endtask : check_all
	initial begin
		void'($urandom(32'hd1f8410e));
		repeat (2) @(posedge CORE_CLK);
		RESET <= 1'b0;
		// Reset values, unmapped address last
		reset_check("reset");
		ticks(20);
		check_all("stopped");
		run = 1'b1;
		wr(ct, 16'h0001);
		rd(ct, 1'b0, 16'h0001, "control");
		ticks($urandom_range(220, 450));
		check_all("tenth");
		msk = 2'h1;
		wr(ma, 16'h0001);
		check_all("mask");
		st = 2'h0;
		wr(sa, 16'h0003);
		check_all("clear");
		// Count writes clear with data ignored, prescaler restarts
		wr(lo, 16'($urandom()));
		acc = 0;
		cnt = cnt / 10 * 10;
		rd(lo, 1'b0, 16'h0000, "low clear");
		wr(hi, 16'($urandom()));
		cnt = 0;
		rd(hi, 1'b0, 16'h0000, "high clear");
		ticks(2);
		check_all("restart2");
		ticks(1);
		check_all("restart3");
		sel = 1'b1;
		msk = 2'h3;
		wr(ma, 16'h0003);
		wr(ct, 16'h0003);
		ticks(2100);
		check_all("second");
		run = 1'b0;
		wr(ct, 16'h0002);
		ticks(30);
		check_all("halt");
		// Read twice while counting, then one word write clears both
		run = 1'b1;
		wr(ct, 16'h0003);
		fork
			ticks(60);
			rd_twice(twice_val);
		join
		check_all("twice");
		wr_word(16'($urandom()));
		acc = 0;
		cnt = 0;
		rd(lo, 1'b1, 16'h0000, "word clear");
		ticks(30);
		// Reset in mid-run returns every register to its reset value
		@(posedge CORE_CLK);
		RESET <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		RESET <= 1'b0;
		acc = 0;
		cnt = 0;
		st = 2'h0;
		msk = 2'h0;
		sel = 1'b0;
		run = 1'b0;
		reset_check("reset again");
		check_all("after reset");
		give_verdict();
	end
endmodule : millisecond_decimal_timer_bench
bind msdt_timer msdt_timer_chk u_msdt_timer_chk (.CORE_CLK(CORE_CLK),
	.RESET(RESET), .TICK_2048HZ(TICK_2048HZ), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_WIDE(REG_WIDE), .REG_RDATA(REG_RDATA),
	.MS_TIMER_IRQ(MS_TIMER_IRQ), .IRQ(IRQ));
